/* pks_if.sv */
// pks_if.sv: two-wire link between master and slave
// assumes: open-drain wires with pull-ups; an enable low means driving
`timescale 1ns/10ps
`default_nettype none
interface pks_if;
  logic sclHostOut;
  logic sclHostOeN;
  logic sdaHostOut;
  logic sdaHostOeN;
  logic sdaDevOut;
  logic sdaDevOeN;
  logic scl;
  logic sda;
  // wired-and with pull-up: low when any driver pulls low
  assign scl = ~(~sclHostOeN & ~sclHostOut);
  assign sda = ~((~sdaHostOeN & ~sdaHostOut) | (~sdaDevOeN & ~sdaDevOut));
  modport host (output sclHostOut, output sclHostOeN, output sdaHostOut,
    output sdaHostOeN, input sda);
  modport dev (output sdaDevOut, output sdaDevOeN, input scl, input sda);
endinterface
`default_nettype wire

/* pks_master.sv */
// pks_master.sv: master end, frames one command per request
// assumes: the slave never stretches scl; one command in flight at a time
`timescale 1ns/10ps
`default_nettype none
module pks_master #(
  parameter int RATE_HZ = pks_pkg::RATE_FAST_HZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link
  pks_if.host bus,
  // command
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [6:0] cmdAddr,
  input wire logic cmdRead,
  input wire logic [3:0] cmdLen,
  // data
  input wire logic [7:0] txData,
  output logic txTake,
  output logic [7:0] rxData,
  output logic rxValid,
  // completion
  output logic done,
  output logic nack
);
  localparam int QCYC = pks_pkg::CLK_HZ / (4 * RATE_HZ);
  if (RATE_HZ > pks_pkg::RATE_HS_HZ || QCYC < 2 || QCYC > 65535)
  begin : g_bad_rate
    $error("pks_master: bit rate out of range");
  end
  localparam logic [15:0] QLAST = 16'(QCYC - 1);

  pks_pkg::pks_mst_state_e state_q;
  logic [15:0] div_q;
  logic tick;
  logic [1:0] phase_q;
  logic [3:0] bitIdx_q;
  logic [8:0] sh_q;
  logic [8:0] rx_q;
  logic [3:0] left_q;
  logic first_q;
  logic rd_q;
  logic [1:0] sdaSync_q;
  logic sclOeN_q;
  logic sdaOeN_q;
  logic [7:0] rxData_q;
  logic rxValid_q;
  logic txTake_q;
  logic done_q;
  logic nack_q;

  // ----------------------------------------------------------------
  // quarter-bit divider and sda synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst || state_q == pks_pkg::PKS_M_IDLE || div_q == QLAST)
    begin
      div_q <= 16'h0000;
    end
    else
    begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign tick = (div_q == QLAST);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sdaSync_q <= 2'h3;
    end
    else
    begin
      sdaSync_q <= {sdaSync_q[0], bus.sda};
    end
  end

  // ----------------------------------------------------------------
  // framing state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= pks_pkg::PKS_M_IDLE;
      phase_q <= 2'h0;
      bitIdx_q <= 4'h0;
      sh_q <= 9'h1FF;
      rx_q <= 9'h000;
      left_q <= 4'h0;
      first_q <= 1'b0;
      rd_q <= 1'b0;
      sclOeN_q <= 1'b1;
      sdaOeN_q <= 1'b1;
      rxData_q <= 8'h00;
      rxValid_q <= 1'b0;
      txTake_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
    end
    else
    begin
      rxValid_q <= 1'b0;
      txTake_q <= 1'b0;
      done_q <= 1'b0;
      unique case (state_q)
        pks_pkg::PKS_M_IDLE:
        begin
          if (cmdValid)
          begin
            state_q <= pks_pkg::PKS_M_START;
            phase_q <= 2'h0;
            left_q <= cmdLen;
            rd_q <= cmdRead;
            first_q <= 1'b1;
            nack_q <= 1'b0;
            sh_q <= {cmdAddr, cmdRead, 1'b1};
          end
        end
        pks_pkg::PKS_M_START:
        begin
          if (tick)
          begin
            phase_q <= phase_q + 2'h1;
            if (phase_q == 2'h1)
            begin
              sdaOeN_q <= 1'b0;  // sda falls while scl high
            end
            else if (phase_q == 2'h2)
            begin
              sclOeN_q <= 1'b0;
              state_q <= pks_pkg::PKS_M_BIT;
              phase_q <= 2'h0;
              bitIdx_q <= 4'h0;
            end
          end
        end
        pks_pkg::PKS_M_BIT:
        begin
          if (tick)
          begin
            phase_q <= phase_q + 2'h1;
            unique case (phase_q)
              2'h0: sdaOeN_q <= sh_q[8];
              2'h1: sclOeN_q <= 1'b1;
              2'h2: rx_q <= {rx_q[7:0], sdaSync_q[1]};
              2'h3:
              begin
                sclOeN_q <= 1'b0;
                sh_q <= {sh_q[7:0], 1'b1};
                bitIdx_q <= bitIdx_q + 4'h1;
                if (bitIdx_q == pks_pkg::BYTE_BITS)
                begin
                  bitIdx_q <= 4'h0;
                  first_q <= 1'b0;
                  if (rd_q && !first_q)
                  begin
                    rxData_q <= rx_q[8:1];
                    rxValid_q <= 1'b1;
                  end
                  if ((first_q || !rd_q) && rx_q[0])
                  begin
                    nack_q <= 1'b1;
                    state_q <= pks_pkg::PKS_M_STOP;
                  end
                  else if (left_q == 4'h0)
                  begin
                    state_q <= pks_pkg::PKS_M_STOP;
                  end
                  else
                  begin
                    left_q <= left_q - 4'h1;
                    txTake_q <= ~rd_q;
                    // last read byte is answered with a nack
                    sh_q <= rd_q ? {8'hFF, left_q == 4'h1} : {txData, 1'b1};
                  end
                end
              end
              default: sdaOeN_q <= 1'b1;
            endcase
          end
        end
        pks_pkg::PKS_M_STOP:
        begin
          if (tick)
          begin
            phase_q <= phase_q + 2'h1;
            unique case (phase_q)
              2'h0: sdaOeN_q <= 1'b0;
              2'h1: sclOeN_q <= 1'b1;
              2'h2: sdaOeN_q <= 1'b1;
              2'h3:
              begin
                done_q <= 1'b1;
                state_q <= pks_pkg::PKS_M_IDLE;
              end
              default: sdaOeN_q <= 1'b1;
            endcase
          end
        end
        default: state_q <= pks_pkg::PKS_M_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmdReady = (state_q == pks_pkg::PKS_M_IDLE);
  assign bus.sclHostOut = 1'b0;
  assign bus.sclHostOeN = sclOeN_q;
  assign bus.sdaHostOut = 1'b0;
  assign bus.sdaHostOeN = sdaOeN_q;
  assign txTake = txTake_q;
  assign rxData = rxData_q;
  assign rxValid = rxValid_q;
  assign done = done_q;
  assign nack = nack_q;
endmodule  // pks_master
`default_nettype wire

/* pks_pkg.sv */
// pks_pkg.sv: constants and types shared by both ends of the key-command link
// assumes: one 250 MHz clock feeds both ends; the pins are resolved in pks_if
package pks_pkg;
  // ----------------------------------------------------------------
  // clock and bus rates
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int RATE_STD_HZ = 100_000;
  localparam int RATE_FAST_HZ = 400_000;
  localparam int RATE_FASTP_HZ = 1_000_000;
  localparam int RATE_HS_HZ = 3_400_000;
  // shortest scl high phase at the top rate, and its cycle count
  localparam int HS_HIGH_MIN_NS = 60;
  localparam int HS_HIGH_MIN_CYC = (HS_HIGH_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // synchroniser plus edge detector delay seen by the slave
  localparam int SYNC_LAT_CYC = 3;
  // ----------------------------------------------------------------
  // key codes and register map of the device outside this block
  // ----------------------------------------------------------------
  localparam logic [7:0] NVM_STORE_SETTINGS_KEY = 8'h66;
  localparam logic [7:0] KEY_RESET = 8'h6A;
  localparam logic [7:0] KEY_RELOAD = 8'h6B;
  localparam logic [7:0] KEY_REBOOT = 8'h6C;
  localparam logic [7:0] KEY_SEQUENCE = 8'h6D;
  localparam logic [7:0] SAVE_FIRST_REG = 8'h03;
  localparam logic [7:0] SAVE_LAST_REG = 8'h23;
  localparam logic [7:0] STATUS_REG = 8'h01;
  // bit 1 save done, bit 0 load ready
  localparam logic [7:0] STATUS_FLAG_MASK = 8'h03;
  localparam logic [7:0] STANDBY_REG = 8'h03;
  localparam int STANDBY_BIT = 6;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] DATA_CNT_MAX = 2'h2;
  // ----------------------------------------------------------------
  // state encodings, gray along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PKS_S_IDLE = 3'h0,
    PKS_S_RECV = 3'h1,
    PKS_S_ACK = 3'h3,
    PKS_S_SEND = 3'h2,
    PKS_S_RDACK = 3'h6
  } pks_slv_state_e;
  typedef enum logic [1:0] {
    PKS_M_IDLE = 2'h0,
    PKS_M_START = 2'h1,
    PKS_M_BIT = 2'h3,
    PKS_M_STOP = 2'h2
  } pks_mst_state_e;
endpackage

/* pks_slave.sv */
// pks_slave.sv: slave end, byte decode, pointer, key commands, status flags
// assumes: scl and sda arrive asynchronously; register file and memory
// engine sit outside on the same clock and answer reads combinationally
`timescale 1ns/10ps
`default_nettype none
module pks_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link
  pks_if.dev bus,
  // register file
  output logic regWrStb,
  output logic [7:0] regWrAddr,
  output logic [7:0] regWrData,
  output logic [7:0] regRdAddr,
  input wire logic [7:0] regRdData,
  // key strobes
  output logic keyStore,
  output logic keyReset,
  output logic keyReload,
  output logic keyReboot,
  output logic keySequence,
  // memory engine status
  input wire logic saveDone,
  input wire logic loadDone,
  output logic saveDoneFlag,
  output logic loadReadyFlag
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pks_pkg::pks_slv_state_e state_q;
  logic [1:0] sclSync_q;
  logic [1:0] sdaSync_q;
  logic sclPrev_q;
  logic sdaPrev_q;
  logic sclR;
  logic sdaR;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [3:0] bitCnt_q;
  logic isAddr_q;
  logic isRead_q;
  logic ackOk_q;
  logic sdaOeN_q;
  logic [1:0] dataCnt_q;
  logic [7:0] ptr_q;
  logic byteDone;
  logic dataByte;
  logic loadByte;
  logic keyHit;
  logic [7:0] rdByte;
  logic regWrStb_q;
  logic [7:0] regWrAddr_q;
  logic [7:0] regWrData_q;
  logic [4:0] keys_q;
  logic saveDone_q;
  logic loadReady_q;

  // ----------------------------------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------------------------------
  // idle bus is high, so reset to high avoids a false start
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end
    else
    begin
      sclSync_q <= {sclSync_q[0], bus.scl};
      sdaSync_q <= {sdaSync_q[0], bus.sda};
      sclPrev_q <= sclSync_q[1];
      sdaPrev_q <= sdaSync_q[1];
    end
  end

  // latency of a few cycles is far below the shortest high phase
  assign sclR = sclSync_q[1];
  assign sdaR = sdaSync_q[1];
  assign sclRise = sclR & ~sclPrev_q;
  assign sclFall = ~sclR & sclPrev_q;
  assign startDet = sclR & sclPrev_q & sdaPrev_q & ~sdaR;
  assign stopDet = sclR & sclPrev_q & ~sdaPrev_q & sdaR;

  // byte events are paced only by host clock edges, never a timer
  assign byteDone = (state_q == pks_pkg::PKS_S_RECV) & sclFall
    & (bitCnt_q == pks_pkg::BYTE_BITS);
  assign dataByte = byteDone & ~isAddr_q;
  assign loadByte = sclFall & (((state_q == pks_pkg::PKS_S_ACK) & isRead_q)
    | ((state_q == pks_pkg::PKS_S_RDACK) & ackOk_q));

  // status flags replace the low bits of the status register
  assign rdByte = (ptr_q == pks_pkg::STATUS_REG)
    ? ((regRdData & ~pks_pkg::STATUS_FLAG_MASK)
      | {6'h00, saveDone_q, loadReady_q}) : regRdData;

  // ----------------------------------------------------------------
  // bit and byte state machine
  // ----------------------------------------------------------------
  // start outranks everything so a stray one cannot leave sda held
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= pks_pkg::PKS_S_IDLE;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      bitCnt_q <= 4'h0;
      isAddr_q <= 1'b0;
      isRead_q <= 1'b0;
      ackOk_q <= 1'b0;
      sdaOeN_q <= 1'b1;
    end
    else if (startDet)
    begin
      state_q <= pks_pkg::PKS_S_RECV;
      bitCnt_q <= 4'h0;
      isAddr_q <= 1'b1;
      isRead_q <= 1'b0;
      sdaOeN_q <= 1'b1;
    end
    else if (stopDet)
    begin
      state_q <= pks_pkg::PKS_S_IDLE;
      sdaOeN_q <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        pks_pkg::PKS_S_IDLE:
        begin
          sdaOeN_q <= 1'b1;
        end
        pks_pkg::PKS_S_RECV:
        begin
          if (sclRise)
          begin
            shift_q <= {shift_q[6:0], sdaR};
            bitCnt_q <= bitCnt_q + 4'h1;
          end
          else if (byteDone)
          begin
            bitCnt_q <= 4'h0;
            if (!isAddr_q || shift_q[7:1] == DEV_ADDR)
            begin
              state_q <= pks_pkg::PKS_S_ACK;
              sdaOeN_q <= 1'b0;
              if (isAddr_q)
              begin
                isRead_q <= shift_q[0];
              end
            end
            else
            begin
              state_q <= pks_pkg::PKS_S_IDLE;  // not ours: stay silent
            end
          end
        end
        pks_pkg::PKS_S_ACK:
        begin
          if (sclFall)
          begin
            isAddr_q <= 1'b0;
            if (isRead_q)
            begin
              state_q <= pks_pkg::PKS_S_SEND;
              tx_q <= rdByte;
              sdaOeN_q <= rdByte[7];  // a one is sent by releasing
            end
            else
            begin
              state_q <= pks_pkg::PKS_S_RECV;
              sdaOeN_q <= 1'b1;
            end
          end
        end
        pks_pkg::PKS_S_SEND:
        begin
          if (sclRise)
          begin
            bitCnt_q <= bitCnt_q + 4'h1;
          end
          else if (sclFall)
          begin
            if (bitCnt_q == pks_pkg::BYTE_BITS)
            begin
              state_q <= pks_pkg::PKS_S_RDACK;
              bitCnt_q <= 4'h0;
              sdaOeN_q <= 1'b1;
            end
            else
            begin
              tx_q <= {tx_q[6:0], 1'b0};
              sdaOeN_q <= tx_q[6];
            end
          end
        end
        pks_pkg::PKS_S_RDACK:
        begin
          if (sclRise)
          begin
            ackOk_q <= ~sdaR;
          end
          else if (sclFall)
          begin
            if (ackOk_q)
            begin
              state_q <= pks_pkg::PKS_S_SEND;
              tx_q <= rdByte;
              sdaOeN_q <= rdByte[7];
            end
            else
            begin
              state_q <= pks_pkg::PKS_S_IDLE;  // nack ends the read
            end
          end
        end
        default:
        begin
          state_q <= pks_pkg::PKS_S_IDLE;
          sdaOeN_q <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register pointer and data byte count
  // ----------------------------------------------------------------
  // pointer survives a repeated start so a read can follow its set-up
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ptr_q <= 8'h00;
    end
    else if (dataByte && dataCnt_q == 2'h0)
    begin
      ptr_q <= shift_q;
    end
    else if (dataByte || loadByte)
    begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // saturates: only "exactly one" matters for key detection
  always_ff @(posedge clock)
  begin
    if (rst || startDet)
    begin
      dataCnt_q <= 2'h0;
    end
    else if (dataByte && dataCnt_q != pks_pkg::DATA_CNT_MAX)
    begin
      dataCnt_q <= dataCnt_q + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // register write port
  // ----------------------------------------------------------------
  // each byte lands at once, so a cut-off burst keeps earlier bytes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      regWrStb_q <= 1'b0;
      regWrAddr_q <= 8'h00;
      regWrData_q <= 8'h00;
    end
    else
    begin
      regWrStb_q <= dataByte && dataCnt_q != 2'h0;
      if (dataByte && dataCnt_q != 2'h0)
      begin
        regWrAddr_q <= ptr_q;
        regWrData_q <= shift_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // key commands
  // ----------------------------------------------------------------
  // decided at stop: a lone byte after a write address is a key
  assign keyHit = stopDet & ~isRead_q & (dataCnt_q == 2'h1);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      keys_q <= 5'h00;
    end
    else
    begin
      keys_q[0] <= keyHit && ptr_q == pks_pkg::NVM_STORE_SETTINGS_KEY;
      keys_q[1] <= keyHit && ptr_q == pks_pkg::KEY_RESET;
      keys_q[2] <= keyHit && ptr_q == pks_pkg::KEY_RELOAD;
      keys_q[3] <= keyHit && ptr_q == pks_pkg::KEY_REBOOT;
      keys_q[4] <= keyHit && ptr_q == pks_pkg::KEY_SEQUENCE;
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  // completion wins over the clear issued in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      saveDone_q <= 1'b0;
    end
    else if (saveDone)
    begin
      saveDone_q <= 1'b1;
    end
    else if (keys_q[0])
    begin
      saveDone_q <= 1'b0;
    end
  end

  // cleared when a reload is asked for, so polling sees the new load
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      loadReady_q <= 1'b0;
    end
    else if (loadDone)
    begin
      loadReady_q <= 1'b1;
    end
    else if (keys_q[2] || keys_q[3])
    begin
      loadReady_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bus.sdaDevOut = 1'b0;
  assign bus.sdaDevOeN = sdaOeN_q;
  assign regWrStb = regWrStb_q;
  assign regWrAddr = regWrAddr_q;
  assign regWrData = regWrData_q;
  assign regRdAddr = ptr_q;
  assign keyStore = keys_q[0];
  assign keyReset = keys_q[1];
  assign keyReload = keys_q[2];
  assign keyReboot = keys_q[3];
  assign keySequence = keys_q[4];
  assign saveDoneFlag = saveDone_q;
  assign loadReadyFlag = loadReady_q;
endmodule  // pks_slave
`default_nettype wire

/* pks_sva.sv */
// pks_sva.sv: assertions on the link wires and the slave's side outputs
// assumes: one clock, synchronous active-high reset, link signals taken from pks_if
`timescale 1ns/10ps
`default_nettype none
module pks_sva (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaDevOeN,
  // slave outputs and engine status
  input wire logic regWrStb,
  input wire logic keyStore,
  input wire logic keyReset,
  input wire logic keyReload,
  input wire logic keyReboot,
  input wire logic keySequence,
  input wire logic saveDone,
  input wire logic loadDone,
  input wire logic saveDoneFlag,
  input wire logic loadReadyFlag
);
  // ----------------------------------------------------------------
  // helpers and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire [4:0] keys = {keySequence, keyReboot, keyReload, keyReset, keyStore};
  logic [3:0] sinceStop_q;
  // saturating age of the last stop, keys may only follow one closely
  always_ff @(posedge clock)
    if (rst) sinceStop_q <= 4'hF;
    else if (scl && $rose(sda)) sinceStop_q <= 4'h0;
    else if (sinceStop_q != 4'hF) sinceStop_q <= sinceStop_q + 4'h1;
  sequence s_store;
    keyStore && !saveDone;
  endsequence
  a_key_single: assert property ($onehot0(keys)) else $error("two keys at once");
  a_key_after_stop: assert property ((|keys) |-> sinceStop_q <= 4'h8)
    else $error("key strobe without a recent stop");
  a_key_pulse: assert property ((|keys) |=> !(|keys)) else $error("key strobe too long");
  a_wr_pulse: assert property (regWrStb |=> !regWrStb) else $error("write strobe too long");
  a_store_clears: assert property (s_store |=> !saveDoneFlag)
    else $error("save flag kept over store");
  a_save_sets: assert property (saveDone |=> saveDoneFlag) else $error("save flag not set");
  a_load_sets: assert property (loadDone |=> loadReadyFlag) else $error("ready flag not set");
  a_flag_keeps: assert property ($fell(saveDoneFlag) |-> $past(keyStore))
    else $error("save flag dropped alone");
  a_ready_keeps: assert property ($fell(loadReadyFlag) |-> $past(keyReload) || $past(keyReboot))
    else $error("ready flag dropped alone");
  a_dev_no_start: assert property ($fell(sdaDevOeN) |-> !scl)
    else $error("slave pulled sda with scl high");
endmodule // pks_sva
`default_nettype wire

/* tb_pmic_i2c_slave_key_commands.sv */
// tb_pmic_i2c_slave_key_commands.sv: master and slave joined, checked end to end
// assumes: pks_pkg, pks_if, pks_master, pks_slave and pks_sva compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_pmic_i2c_slave_key_commands;
  // ----------------------------------------------------------------
  // signals and models
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [7:0] KEYS [5] = '{8'h66, 8'h6A, 8'h6B, 8'h6C, 8'h6D};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmdValid = 1'b0;
  logic cmdRead = 1'b0;
  logic [6:0] cmdAddr = 7'h00;
  logic [3:0] cmdLen = 4'h0;
  logic [7:0] txBuf [4] = '{default: 8'h00};
  logic [1:0] txIdx = 2'h0;
  logic saveDone = 1'b0;
  logic loadDone = 1'b0;
  logic [15:0] storeSh = 16'h0000;
  logic [15:0] loadSh = 16'h0000;
  logic [7:0] txData, rxData, regWrAddr, regWrData, regRdAddr, regRdData;
  logic cmdReady, txTake, rxValid, done, nack, regWrStb, saveDoneFlag, loadReadyFlag;
  logic keyStore, keyReset, keyReload, keyReboot, keySequence;
  logic [7:0] regs [256];
  logic [7:0] rxQ [$];
  int keyCnt [5] = '{default: 0};
  logic sclP = 1'b1;
  logic sdaP = 1'b1;
  logic [3:0] bitCnt = 4'h8;
  logic [7:0] shReg = 8'h00;
  logic [7:0] firstByte = 8'h00;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  wire [4:0] kv = {keySequence, keyReboot, keyReload, keyReset, keyStore};
  pks_if link();
  pks_master #(.RATE_HZ(pks_pkg::RATE_HS_HZ)) i_pks_master (.clock(clock), .rst(rst),
    .bus(link.host), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdAddr(cmdAddr),
    .cmdRead(cmdRead), .cmdLen(cmdLen), .txData(txData), .txTake(txTake), .rxData(rxData),
    .rxValid(rxValid), .done(done), .nack(nack));
  pks_slave i_pks_slave (.clock(clock), .rst(rst), .bus(link.dev), .regWrStb(regWrStb),
    .regWrAddr(regWrAddr), .regWrData(regWrData), .regRdAddr(regRdAddr),
    .regRdData(regRdData), .keyStore(keyStore), .keyReset(keyReset), .keyReload(keyReload),
    .keyReboot(keyReboot), .keySequence(keySequence), .saveDone(saveDone),
    .loadDone(loadDone), .saveDoneFlag(saveDoneFlag), .loadReadyFlag(loadReadyFlag));
  pks_sva i_pks_sva (.clock(clock), .rst(rst), .scl(link.scl), .sda(link.sda),
    .sdaDevOeN(link.sdaDevOeN), .regWrStb(regWrStb), .keyStore(keyStore),
    .keyReset(keyReset), .keyReload(keyReload), .keyReboot(keyReboot),
    .keySequence(keySequence), .saveDone(saveDone), .loadDone(loadDone),
    .saveDoneFlag(saveDoneFlag), .loadReadyFlag(loadReadyFlag));
  assign txData = txBuf[txIdx];
  assign regRdData = regs[regRdAddr];
  always #2 clock = ~clock;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one frame; the tail lets the slave's stop-decoded key land
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [3:0] n);
    int i;
    @(posedge clock);
    cmdAddr <= a;
    cmdRead <= rd;
    cmdLen <= n;
    cmdValid <= 1'b1;
    @(posedge clock);
    cmdValid <= 1'b0;
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
    end while (done !== 1'b1 && i < 20000);
    chk({7'h00, done}, 8'h01);
    repeat (8) @(posedge clock);
  endtask
  // register file, memory engine with a fixed delay, wire monitor, watchdog
  always @(posedge clock)
  begin
    if (rst) for (int k = 0; k < 256; k++) regs[k] <= 8'h00;
    else if (regWrStb) regs[regWrAddr] <= regWrData;
    storeSh <= {storeSh[14:0], keyStore};
    loadSh <= {loadSh[14:0], keyReload | keyReboot};
    saveDone <= storeSh[15];
    loadDone <= loadSh[15];
    if (cmdValid) txIdx <= 2'h0;
    else if (txTake) txIdx <= txIdx + 2'h1;
    if (rxValid) rxQ.push_back(rxData);
    for (int k = 0; k < 5; k++) keyCnt[k] <= keyCnt[k] + int'(kv[k]);
    sclP <= link.scl;
    sdaP <= link.sda;
    if (link.scl && sclP && sdaP && !link.sda) bitCnt <= 4'h0;
    else if (link.scl && !sclP && bitCnt < 4'h8)
    begin
      shReg <= {shReg[6:0], link.sda};
      bitCnt <= bitCnt + 4'h1;
      if (bitCnt == 4'h7) firstByte <= {shReg[6:0], link.sda};
    end
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      fails++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk({3'h0, cmdReady, link.scl, link.sda, saveDoneFlag, loadReadyFlag}, 8'h1C);
    txBuf <= '{8'h10, 8'hAA, 8'h55, 8'hC3};
    xfer(ADDR, 1'b0, 4'h4);
    chk(firstByte, {ADDR, 1'b0});
    chk({7'h00, nack}, 8'h00);
    for (int k = 0; k < 3; k++) chk(regs[8'h10 + k], txBuf[k + 1]);
    xfer(ADDR, 1'b0, 4'h1);
    rxQ.delete();
    xfer(ADDR, 1'b1, 4'h3);
    chk(firstByte, {ADDR, 1'b1});
    for (int k = 0; k < 3; k++) chk(rxQ[k], txBuf[k + 1]);
    txBuf[0] <= 8'h66;
    xfer(ADDR ^ 7'h01, 1'b0, 4'h1);
    chk({7'h00, nack}, 8'h01);
    chk(keyCnt[0][7:0], 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      txBuf[0] <= KEYS[k];
      xfer(ADDR, 1'b0, 4'h1);
      chk(keyCnt[k][7:0], 8'h01);
    end
    repeat (40) @(posedge clock);
    chk({6'h00, saveDoneFlag, loadReadyFlag}, 8'h03);
    txBuf[0] <= pks_pkg::STATUS_REG;
    xfer(ADDR, 1'b0, 4'h1);
    rxQ.delete();
    xfer(ADDR, 1'b1, 4'h1);
    chk(rxQ[0], 8'h03);
    txBuf <= '{8'h66, 8'h77, 8'h00, 8'h00};
    xfer(ADDR, 1'b0, 4'h2);
    chk(regs[8'h66], 8'h77);
    chk(keyCnt[0][7:0], 8'h01);
    txBuf[0] <= 8'h66;
    xfer(ADDR, 1'b0, 4'h1);
    repeat (40) @(posedge clock);
    chk({7'h00, saveDoneFlag}, 8'h01);
    print_verdict();
  end
endmodule // tb_pmic_i2c_slave_key_commands
`default_nettype wire
